// >>> core/i2cstp_pkg.sv
// Behaviour
// [RQ1] Stop drives data low first; clock released only after data sampled low.
// [RQ2] Released clock sampled high (stretch honoured), rate counter loads reload.
// [RQ3] Data released then sampled at counter timeout; low means bus collision.
// [RQ4] Clock sampled low before data rises during Stop is a collision.
// [RQ5] Collision sets bus collision flag and returns port logic to idle.
// [RQ6] Collision aborts condition, releases both lines, clears stop request bit.
// [RQ7] Clean Stop: data released, stop-seen set, stop request cleared, event flag.
// [RQ8] Bus line levels pass two flip-flops before any decision reads them.
`default_nettype none
package i2cstp_pkg;
  localparam logic [11:0] ADDR_RELOAD  = 12'h000;
  localparam logic [11:0] ADDR_BUF     = 12'h004;
  localparam logic [11:0] ADDR_CTRL1   = 12'h008;
  localparam logic [11:0] ADDR_CTRL2   = 12'h00C;
  localparam logic [11:0] ADDR_CTRL3   = 12'h010;
  localparam logic [11:0] ADDR_MASK    = 12'h014;
  localparam logic [11:0] ADDR_STATUS  = 12'h018;
  localparam logic [11:0] ADDR_IRQ_ST  = 12'h01C;
  localparam logic [11:0] ADDR_IRQ_EN  = 12'h020;
  // Field positions
  localparam int CTRL2_STOP_REQ_BIT = 2;
  localparam int CTRL1_ENABLE_BIT   = 5;
  localparam int CTRL1_WCOL_BIT     = 7;
  localparam int STATUS_STOP_BIT    = 4;
  localparam int IRQ_EVENT_BIT      = 0;
  localparam int IRQ_COLL_BIT       = 1;
  // Reset values
  localparam logic [7:0] RELOAD_RST = 8'h09;
  localparam logic [7:0] REG_RST    = 8'h00;
  typedef enum logic [2:0] {
    I2CSTP_IDLE, I2CSTP_DRIVE_SDA, I2CSTP_WAIT_SCL, I2CSTP_HOLD,
    I2CSTP_SAMPLE_SDA, I2CSTP_TAIL
  } i2cstp_state_t;
endpackage
`default_nettype wire

// >>> core/i2cstp_sync.sv
`default_nettype none
module i2cstp_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff  <= '1;
      sync_out <= '1;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// >>> core/i2cstp_top.sv
// Local design decisions: the register offsets and the APB register port.
`default_nettype none
module i2cstp_top
  import i2cstp_pkg::*;
(
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Two-wire bus, open drain
  input  wire logic        serial_data_pin_in,
  output logic             serial_data_pin_out,
  output logic             serial_data_pin_oe,
  input  wire logic        serial_clock_pin_in,
  output logic             serial_clock_pin_out,
  output logic             serial_clock_pin_oe,
  // Interrupt
  output logic             irq
);
  ////////////////////////////////////////////////////////////////////////
  logic [7:0]    reload_value_register_ff;
  logic [7:0]    buf_ff;
  logic [7:0]    ctrl1_ff;
  logic [7:0]    port_control_second_ff;
  logic [7:0]    ctrl3_ff;
  logic [7:0]    mask_ff;
  logic          stop_seen_ff;
  logic [1:0]    irq_st_ff;
  logic [1:0]    irq_en_ff;
  logic [7:0]    rate_counter_ff;
  logic          sda_low_ff;
  logic          scl_low_ff;
  i2cstp_state_t state_ff;
  i2cstp_state_t nxt_state;
  logic          sda_s;
  logic          scl_s;
  logic          wr_en;
  logic          rd_en;
  logic          addr_ok;
  logic          stop_done;
  logic          collision;
  logic          counter_zero;
  logic          counter_load;
  logic          stop_seen_set;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    return a == r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bus line synchroniser
  i2cstp_sync #(.W(2)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({serial_data_pin_in, serial_clock_pin_in}),
    .sync_out ({sda_s, scl_s})  // [RQ8]
  );

  ////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  assign pready = 1'b1;
  assign wr_en  = psel && penable && pwrite;
  assign rd_en  = psel && !penable && !pwrite;
  always_comb begin
    addr_ok = hit(paddr, ADDR_RELOAD) || hit(paddr, ADDR_BUF)
           || hit(paddr, ADDR_CTRL1) || hit(paddr, ADDR_CTRL2)
           || hit(paddr, ADDR_CTRL3) || hit(paddr, ADDR_MASK)
           || hit(paddr, ADDR_STATUS) || hit(paddr, ADDR_IRQ_ST)
           || hit(paddr, ADDR_IRQ_EN);
  end
  assign pslverr = psel && penable && !addr_ok;

  // Read data captured in setup so it is stable during access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      case (paddr)
        ADDR_RELOAD: prdata <= {24'h000000, reload_value_register_ff};
        ADDR_BUF:    prdata <= {24'h000000, buf_ff};
        ADDR_CTRL1:  prdata <= {24'h000000, ctrl1_ff};
        ADDR_CTRL2:  prdata <= {24'h000000, port_control_second_ff};
        ADDR_CTRL3:  prdata <= {24'h000000, ctrl3_ff};
        ADDR_MASK:   prdata <= {24'h000000, mask_ff};
        ADDR_STATUS: prdata <= {27'h0000000, stop_seen_ff, 4'h0};
        ADDR_IRQ_ST: prdata <= {30'h00000000, irq_st_ff};
        ADDR_IRQ_EN: prdata <= {30'h00000000, irq_en_ff};
        default:     prdata <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Plain registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_value_register_ff <= RELOAD_RST;
      ctrl3_ff                 <= REG_RST;
      mask_ff                  <= REG_RST;
      irq_en_ff                <= 2'h0;
    end else if (wr_en) begin
      if (hit(paddr, ADDR_RELOAD)) reload_value_register_ff <= pwdata[7:0];
      if (hit(paddr, ADDR_CTRL3))  ctrl3_ff  <= pwdata[7:0];
      if (hit(paddr, ADDR_MASK))   mask_ff   <= pwdata[7:0];
      if (hit(paddr, ADDR_IRQ_EN)) irq_en_ff <= pwdata[1:0];
    end
  end

  // Buffer write during a Stop is refused and flags a write collision
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_ff   <= REG_RST;
      ctrl1_ff <= REG_RST;
    end else if (wr_en && hit(paddr, ADDR_BUF)) begin
      if (state_ff != I2CSTP_IDLE) begin
        ctrl1_ff[CTRL1_WCOL_BIT] <= 1'b1;
      end else begin
        buf_ff <= pwdata[7:0];
      end
    end else if (wr_en && hit(paddr, ADDR_CTRL1)) begin
      ctrl1_ff <= pwdata[7:0];
    end
  end

  // Stop request: hardware clear takes precedence over disable and software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_control_second_ff <= REG_RST;
    end else if (collision || stop_done) begin
      port_control_second_ff[CTRL2_STOP_REQ_BIT] <= 1'b0;  // [RQ6] [RQ7]
    end else if (!ctrl1_ff[CTRL1_ENABLE_BIT]) begin
      port_control_second_ff <= REG_RST;
    end else if (wr_en && hit(paddr, ADDR_CTRL2)) begin
      port_control_second_ff <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Rate counter
  assign counter_zero = (rate_counter_ff == 8'h00);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_counter_ff <= 8'h00;
    end else if (counter_load) begin
      rate_counter_ff <= reload_value_register_ff;  // [RQ2]
    end else if (!counter_zero) begin
      rate_counter_ff <= rate_counter_ff - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stop sequencer
  always_comb begin
    nxt_state     = state_ff;
    counter_load  = 1'b0;
    collision     = 1'b0;
    stop_done     = 1'b0;
    stop_seen_set = 1'b0;
    case (state_ff)
      I2CSTP_IDLE: begin
        if (ctrl1_ff[CTRL1_ENABLE_BIT]
            && port_control_second_ff[CTRL2_STOP_REQ_BIT]) begin
          nxt_state = I2CSTP_DRIVE_SDA;
        end
      end
      I2CSTP_DRIVE_SDA: begin
        if (!sda_s) begin
          nxt_state = I2CSTP_WAIT_SCL;  // [RQ1]
        end
      end
      I2CSTP_WAIT_SCL: begin
        if (scl_s) begin
          counter_load = 1'b1;  // [RQ2]
          nxt_state    = I2CSTP_HOLD;
        end
      end
      I2CSTP_HOLD: begin
        if (!scl_s) begin
          collision = 1'b1;  // [RQ4]
        end else if (counter_zero) begin
          counter_load = 1'b1;  // [RQ7]
          nxt_state    = I2CSTP_SAMPLE_SDA;
        end
      end
      I2CSTP_SAMPLE_SDA: begin
        if (!scl_s && !sda_s) begin
          collision = 1'b1;  // [RQ4]
        end else if (counter_zero) begin
          if (!sda_s) begin
            collision = 1'b1;  // [RQ3]
          end else begin
            counter_load = 1'b1;
            nxt_state    = I2CSTP_TAIL;
          end
        end
        if (sda_s && scl_s) begin
          stop_seen_set = 1'b1;  // [RQ7]
        end
      end
      I2CSTP_TAIL: begin
        if (counter_zero) begin
          stop_done = 1'b1;  // [RQ7]
          nxt_state = I2CSTP_IDLE;
        end
      end
      default: nxt_state = I2CSTP_IDLE;
    endcase
    if (collision) begin
      nxt_state = I2CSTP_IDLE;  // [RQ5]
    end
    if (!ctrl1_ff[CTRL1_ENABLE_BIT]) begin
      nxt_state = I2CSTP_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= I2CSTP_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Line drive: collision or idle releases both lines
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_low_ff <= 1'b0;
      scl_low_ff <= 1'b0;
    end else begin
      case (nxt_state)
        I2CSTP_DRIVE_SDA: begin
          sda_low_ff <= 1'b1;  // [RQ1]
          scl_low_ff <= 1'b1;
        end
        I2CSTP_WAIT_SCL, I2CSTP_HOLD: begin
          sda_low_ff <= 1'b1;
          scl_low_ff <= 1'b0;  // [RQ1]
        end
        default: begin
          sda_low_ff <= 1'b0;  // [RQ6] [RQ7]
          scl_low_ff <= 1'b0;
        end
      endcase
    end
  end

  assign serial_data_pin_out  = 1'b0;
  assign serial_data_pin_oe   = sda_low_ff;
  assign serial_clock_pin_out = 1'b0;
  assign serial_clock_pin_oe  = scl_low_ff;

  ////////////////////////////////////////////////////////////////////////
  // Stop-seen status, cleared when a new Stop is requested or port off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_seen_ff <= 1'b0;
    end else if (stop_seen_set) begin
      stop_seen_ff <= 1'b1;  // [RQ7]
    end else if (!ctrl1_ff[CTRL1_ENABLE_BIT]
                 || state_ff == I2CSTP_DRIVE_SDA) begin
      stop_seen_ff <= 1'b0;
    end
  end

  // Sticky events; set beats write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_ff <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (i == IRQ_EVENT_BIT && stop_done) begin
          irq_st_ff[i] <= 1'b1;  // [RQ7]
        end else if (i == IRQ_COLL_BIT && collision) begin
          irq_st_ff[i] <= 1'b1;  // [RQ5]
        end else if (wr_en && hit(paddr, ADDR_IRQ_ST) && pwdata[i]) begin
          irq_st_ff[i] <= 1'b0;
        end
      end
    end
  end

  assign irq = |(irq_st_ff & irq_en_ff);
endmodule
`default_nettype wire

// >>> verif/i2cstp_sva.sv
`default_nettype none
module i2cstp_sva
  import i2cstp_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  // Bus and interrupt
  input wire logic        serial_data_pin_in,
  input wire logic        serial_data_pin_oe,
  input wire logic        serial_clock_pin_in,
  input wire logic        serial_clock_pin_oe,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_high: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  chk_unmapped_err: assert property (
    psel && penable && paddr > 12'h020 |-> pslverr)
    else $error("unmapped access without error");
  chk_sda_first: assert property (
    serial_clock_pin_oe |-> serial_data_pin_oe)
    else $error("clock held low without data held low");
  chk_scl_release_order: assert property (
    $fell(serial_clock_pin_oe) && serial_data_pin_oe
    |-> !$past(serial_data_pin_in) && !$past(serial_data_pin_in, 2))
    else $error("clock released before data seen low");
  chk_hold_time: assert property (
    $fell(serial_data_pin_oe) && serial_clock_pin_in
    |-> $past(serial_clock_pin_in) && $past(serial_clock_pin_in, 2)
        && $past(serial_clock_pin_in, 3))
    else $error("data released too soon after clock high");
  chk_collide_scl: assert property (
    serial_data_pin_oe && !serial_clock_pin_oe && $fell(serial_clock_pin_in)
    |-> ##[1:5] !serial_data_pin_oe)
    else $error("clock pulled low but stop not aborted");
  chk_irq_released: assert property (
    $rose(irq) && !$past(psel)
    |-> !serial_data_pin_oe && !serial_clock_pin_oe)
    else $error("flag raised while a line is still driven");
  // Bound assumes other parties stretch only briefly
  chk_stop_ends: assert property (
    $rose(serial_data_pin_oe) |-> ##[1:1000] !serial_data_pin_oe)
    else $error("stop never released the data line");
endmodule
bind i2cstp_top i2cstp_sva chk_u (.pclk, .presetn, .psel, .penable, .paddr,
  .pready, .pslverr, .serial_data_pin_in, .serial_data_pin_oe,
  .serial_clock_pin_in, .serial_clock_pin_oe, .irq);
`default_nettype wire

// >>> verif/i2cstp_bus.sv
`default_nettype none
module i2cstp_bus (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Scenario: 0 polite, 1 grab data, 2 grab clock
  input  wire logic [1:0] mode,
  input  wire logic [7:0] stretch,
  // Device pins
  input  wire logic       serial_data_pin_out,
  input  wire logic       serial_data_pin_oe,
  input  wire logic       serial_clock_pin_out,
  input  wire logic       serial_clock_pin_oe,
  // Line levels seen by all parties
  output logic            serial_data_pin_in,
  output logic            serial_clock_pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_ff;
  logic       scl_pull_ff;
  logic       sda_pull_ff;
  // Pull-ups: a released line reads high
  assign serial_data_pin_in  = !((serial_data_pin_oe && !serial_data_pin_out)
                                 || sda_pull_ff);
  assign serial_clock_pin_in = !((serial_clock_pin_oe && !serial_clock_pin_out)
                                 || scl_pull_ff);
  // Stretcher already holds the clock while the device does, so the
  // release shows no high glitch before the stretch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff      <= 8'h00;
      scl_pull_ff <= 1'b0;
    end else if (serial_clock_pin_oe) begin
      cnt_ff      <= (mode == 2'h2) ? stretch + 8'h04 : stretch;
      scl_pull_ff <= (mode != 2'h2) && (stretch != 8'h00);
    end else if (cnt_ff != 8'h00) begin
      cnt_ff <= cnt_ff - 8'h01;
      if (cnt_ff == 8'h01) scl_pull_ff <= (mode == 2'h2);
    end else if (mode == 2'h0) begin
      scl_pull_ff <= 1'b0;
    end
  end
  // Rival master drives zero already, so data never floats high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sda_pull_ff <= 1'b0;
    else if (serial_data_pin_oe && mode == 2'h1) sda_pull_ff <= 1'b1;
    else if (mode == 2'h0) sda_pull_ff <= 1'b0;
  end
endmodule
`default_nettype wire

// >>> verif/test_i2cstp.sv
`default_nettype none
module test_i2cstp
  import i2cstp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [1:0]  mode;
  logic [7:0]  stretch;
  logic        serial_data_pin_in, serial_data_pin_out, serial_data_pin_oe;
  logic        serial_clock_pin_in, serial_clock_pin_out, serial_clock_pin_oe;
  int          mismatches = 0;
  int          n_tests = 0;
  always #5 pclk = ~pclk;
  i2cstp_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .serial_data_pin_in,
    .serial_data_pin_out, .serial_data_pin_oe, .serial_clock_pin_in,
    .serial_clock_pin_out, .serial_clock_pin_oe, .irq);
  i2cstp_bus bus_u (.pclk, .presetn, .mode, .stretch, .serial_data_pin_in,
    .serial_data_pin_out, .serial_data_pin_oe, .serial_clock_pin_in,
    .serial_clock_pin_out, .serial_clock_pin_oe);
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      complete_run();
    end
    rdata = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    mode = 2'h0;
    stretch = 8'h00;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ADDR_RELOAD, 32'h0);
    check(rdata, 32'(RELOAD_RST));
    apb(1'b0, 12'h040, 32'h0);
    check({err, rdata[30:0]}, 32'h80000000);
    apb(1'b1, ADDR_RELOAD, 32'h08);
    apb(1'b0, ADDR_RELOAD, 32'h0);
    check(rdata, 32'h08);
    $display("register test done");
    apb(1'b1, ADDR_IRQ_EN, 32'h3);
    apb(1'b1, ADDR_CTRL1, 32'h20);
    for (int t = 0; t < 3; t++) begin
      mode    <= 2'(t);
      stretch <= (t == 0) ? 8'h1E : 8'h00;
      apb(1'b1, ADDR_CTRL2, 32'h1 << CTRL2_STOP_REQ_BIT);
      if (t == 0) begin
        // Buffer write during Stop must be dropped and flagged
        apb(1'b1, ADDR_BUF, 32'h5A);
        apb(1'b0, ADDR_CTRL1, 32'h0);
        check(rdata, 32'hA0);
        apb(1'b0, ADDR_BUF, 32'h0);
        check(rdata, 32'(REG_RST));
        apb(1'b1, ADDR_CTRL1, 32'h20);
      end
      for (int k = 0; k < 100; k++) begin
        apb(1'b0, ADDR_CTRL2, 32'h0);
        if (rdata[CTRL2_STOP_REQ_BIT] === 1'b0) break;
      end
      check(32'(rdata[CTRL2_STOP_REQ_BIT]), 32'h0);
      if (rdata[CTRL2_STOP_REQ_BIT] !== 1'b0) complete_run();
      apb(1'b0, ADDR_IRQ_ST, 32'h0);
      check(32'(rdata[IRQ_COLL_BIT]), 32'(t != 0));
      check(32'(rdata[IRQ_EVENT_BIT]), 32'(t == 0));
      check({serial_data_pin_oe, serial_clock_pin_oe}, 32'h0);
      check({serial_data_pin_out, serial_clock_pin_out}, 32'h0);
      check(32'(irq), 32'h1);
      apb(1'b1, ADDR_IRQ_EN, 32'h0);
      check(32'(irq), 32'h0);
      apb(1'b1, ADDR_IRQ_ST, 32'h3);
      apb(1'b1, ADDR_IRQ_EN, 32'h3);
      check(32'(irq), 32'h0);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check(32'(rdata[STATUS_STOP_BIT]), 32'(t == 0));
      mode <= 2'h0;
      // Let the rival see idle mode and let go before the next scenario
      @(posedge pclk);
      $display("stop test %0d done", t);
    end
    complete_run();
  end
endmodule
`default_nettype wire
